// file: shared/pfc_pkg.sv
package pfc_pkg;
  localparam int unsigned ClkHz = 10_000_000;
  localparam int unsigned OscHz = 1_000_000;
  localparam logic [3:0] OscDiv = 4'(ClkHz / OscHz);
  localparam int unsigned LatchTimeoutUs = 500;
  localparam int unsigned OffTimeoutUs = 500;
  localparam logic [9:0] LatchTicks = 10'(LatchTimeoutUs * OscHz / 1_000_000);
  localparam logic [9:0] OffTicks = 10'(OffTimeoutUs * OscHz / 1_000_000);
  localparam logic [1:0] FilterCycles = 2'h3;
  // Timer capacitance in 0.01 uF units; 10 s per uF gives 100 ms per unit
  localparam int unsigned MsPerCapUnit = 100;
  localparam logic [9:0] TicksPerMs = 10'(OscHz / 1000);
  localparam logic [7:0] TimerCapReset = 8'h0A;
  localparam logic [4:0] LevelMax = 5'h10;
  localparam logic [4:0] FlashGroupTop = 5'h04;
  localparam logic [11:0] AddrTimerCap = 12'h000;
  localparam logic [11:0] AddrStatus = 12'h004;
  localparam logic [11:0] AddrPending = 12'h008;
  // Output current per level in tenths of a percent, index 0 is off
  localparam logic [9:0] PctTable [0:16] = '{
    10'h000, 10'h3E8, 10'h37B, 10'h31A, 10'h2C4, 10'h277, 10'h232, 10'h1F5,
    10'h1BF, 10'h18E, 10'h163, 10'h13C, 10'h11A, 10'h0FB, 10'h0E0, 10'h0C8,
    10'h000};
  typedef enum logic [1:0] {
    PUMP_1X = 2'h1,
    PUMP_1P5X = 2'h2,
    PUMP_2X = 2'h3
  } pfc_pump_t;
  typedef enum logic [1:0] {
    LIGHT_OFF = 2'h0,
    LIGHT_FLASH = 2'h1,
    LIGHT_TORCH = 2'h2
  } pfc_light_t;
  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b01,
    ST_RUN = 2'b10
  } pfc_state_t;
  typedef struct packed {
    logic timerExpired;
    logic timerArmed;
    logic outputOn;
    logic shutdown;
    pfc_light_t lightMode;
    pfc_pump_t pumpMode;
    logic [4:0] levelCode;
  } pfc_status_t;
endpackage

// file: hdl/pfc_flash_ctrl.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Count clean rising edges on the control pin into a level code of 16.
// - After control high for latch timeout, apply count to output, clear count.
// - All timeouts run off a derived 1 MHz oscillator tick; the glitch filter counts clocks.
// - Levels 1 to 16 map to the fixed percentage table, 16 is zero.
// - Control held low past the off timeout enters shutdown, output off.
// - Shutdown clears the pending count and the latched level.
// - Flash timer armed only for latched levels 1 to 4.
// - Moving from levels 1-4 to 5-16 ignores any running flash timer.
// - Moving from levels 5-16 to 1-4 restarts the flash timer.
// - Every new latched level resets the pump stage and mode.
// - Flash timeout is 10 seconds per microfarad of timer capacitance.
// - An expired armed flash timer turns the output off by itself.
// - Timer pin held at ground disables the timer for any level.
// - Shutdown or level 0 gives off; otherwise select low flash, high torch.
// - Pump starts in 1X, steps to 1.5X then 2X while headroom is short.
module pfc_flash_ctrl
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enSetPin,
  input wire logic flashTorchSelectInput,
  input wire logic timerCapacitorPinLow,
  input wire logic headroomShort,
  output logic [4:0] levelCode,
  output logic [9:0] currentTenthPct,
  output logic outputOn,
  output pfc_light_t lightMode,
  output pfc_pump_t pumpMode,
  output logic pumpReset,
  output logic shutdown
);

  pfc_state_t state_reg;
  logic [3:0] divCnt_reg;
  logic oscTick_reg;
  logic enSync2_reg;
  logic selSync2_reg;
  logic enClean_reg;
  logic enPrev_reg;
  logic [1:0] filtCnt_reg;
  logic [9:0] highCnt_reg;
  logic [9:0] lowCnt_reg;
  logic [4:0] pending_reg;
  logic [4:0] level_reg;
  logic [7:0] timerCap_reg;
  logic [9:0] msDiv_reg;
  logic [23:0] msCnt_reg;
  logic timerExpired_reg;
  logic latchNow;
  logic offNow;
  logic riseNow;
  logic newHigh;
  logic oldHigh;
  logic timerArmed;
  logic [23:0] timerLimit;
  logic apbSetup;
  logic apbWrite;
  pfc_status_t status;

  // 1 MHz oscillator tick from the 10 MHz clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCnt_reg <= 4'h0;
      oscTick_reg <= 1'b0;
    end else if (divCnt_reg == OscDiv - 4'h1) begin
      divCnt_reg <= 4'h0;
      oscTick_reg <= 1'b1;
    end else begin
      divCnt_reg <= divCnt_reg + 4'h1;
      oscTick_reg <= 1'b0;
    end
  end

  // Select line is only synchronised; its level is used, never its edges
  pfc_sync2 enSyncInst (
    .clk(clk),
    .reset(reset),
    .d(enSetPin),
    .q(enSync2_reg)
  );

  pfc_sync2 selSyncInst (
    .clk(clk),
    .reset(reset),
    .d(flashTorchSelectInput),
    .q(selSync2_reg)
  );

  // Glitch filter: level must hold a few clocks before it is believed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filtCnt_reg <= 2'h0;
      enClean_reg <= 1'b0;
      enPrev_reg <= 1'b0;
    end else begin
      enPrev_reg <= enClean_reg;
      if (enSync2_reg == enClean_reg) begin
        filtCnt_reg <= 2'h0;
      end else if (filtCnt_reg == FilterCycles - 2'h1) begin
        filtCnt_reg <= 2'h0;
        enClean_reg <= enSync2_reg;
      end else begin
        filtCnt_reg <= filtCnt_reg + 2'h1;
      end
    end
  end

  assign riseNow = enClean_reg & ~enPrev_reg;

  // High and low time counters in oscillator ticks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      highCnt_reg <= 10'h000;
      lowCnt_reg <= 10'h000;
    end else if (enClean_reg != enPrev_reg) begin
      highCnt_reg <= 10'h000;
      lowCnt_reg <= 10'h000;
    end else if (oscTick_reg) begin
      if (enClean_reg && highCnt_reg != LatchTicks) begin
        highCnt_reg <= highCnt_reg + 10'h001;
      end
      if (!enClean_reg && lowCnt_reg != OffTicks) begin
        lowCnt_reg <= lowCnt_reg + 10'h001;
      end
    end
  end

  // Fires once per high period; an empty count latches nothing
  assign latchNow = enClean_reg && oscTick_reg && highCnt_reg == LatchTicks - 10'h001
    && pending_reg != 5'h00;
  assign offNow = !enClean_reg && oscTick_reg && lowCnt_reg == OffTicks - 10'h001;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_SHUTDOWN;
    end else begin
      case (state_reg)
        ST_SHUTDOWN: begin
          if (riseNow) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (offNow) begin
            state_reg <= ST_SHUTDOWN;
          end
        end
        default: begin
          state_reg <= ST_SHUTDOWN;
        end
      endcase
    end
  end

  // Pending edge count and latched level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_reg <= 5'h00;
      level_reg <= 5'h00;
    end else if (offNow) begin
      pending_reg <= 5'h00;
      level_reg <= 5'h00;
    end else if (latchNow) begin
      level_reg <= pending_reg;
      pending_reg <= 5'h00;
    end else if (riseNow && pending_reg != LevelMax) begin
      pending_reg <= pending_reg + 5'h01;
    end
  end

  assign newHigh = pending_reg <= FlashGroupTop;
  assign oldHigh = level_reg != 5'h00 && level_reg <= FlashGroupTop;
  assign timerArmed = level_reg != 5'h00 && level_reg <= FlashGroupTop
    && !timerCapacitorPinLow;
  assign timerLimit = 24'(timerCap_reg) * 24'(MsPerCapUnit);

  // Flash timer in milliseconds
  // A shutdown, or a latch into or out of levels 1-4, in the expiry cycle wins, so timing restarts cleanly
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      msDiv_reg <= 10'h000;
      msCnt_reg <= 24'h000000;
      timerExpired_reg <= 1'b0;
    end else if (offNow || (latchNow && !newHigh)) begin
      msDiv_reg <= 10'h000;
      msCnt_reg <= 24'h000000;
      timerExpired_reg <= 1'b0;
    end else if (latchNow && newHigh && !oldHigh) begin
      msDiv_reg <= 10'h000;
      msCnt_reg <= 24'h000000;
      timerExpired_reg <= 1'b0;
    end else if (!timerArmed) begin
      msDiv_reg <= 10'h000;
      msCnt_reg <= 24'h000000;
      timerExpired_reg <= 1'b0;
    end else if (!timerExpired_reg && oscTick_reg) begin
      if (msDiv_reg == TicksPerMs - 10'h001) begin
        msDiv_reg <= 10'h000;
        if (msCnt_reg + 24'h000001 >= timerLimit) begin
          timerExpired_reg <= 1'b1;
        end else begin
          msCnt_reg <= msCnt_reg + 24'h000001;
        end
      end else begin
        msDiv_reg <= msDiv_reg + 10'h001;
      end
    end
  end

  // Pump mode steps up only on oscillator ticks so each mode can settle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pumpMode <= PUMP_1X;
      pumpReset <= 1'b0;
    end else if (latchNow || offNow) begin
      pumpMode <= PUMP_1X;
      pumpReset <= 1'b1;
    end else begin
      pumpReset <= 1'b0;
      if (oscTick_reg && headroomShort && outputOn) begin
        case (pumpMode)
          PUMP_1X: begin
            pumpMode <= PUMP_1P5X;
          end
          PUMP_1P5X: begin
            pumpMode <= PUMP_2X;
          end
          default: begin
            pumpMode <= PUMP_2X;
          end
        endcase
      end
    end
  end

  // Output stage, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      levelCode <= 5'h00;
      currentTenthPct <= 10'h000;
      outputOn <= 1'b0;
      lightMode <= LIGHT_OFF;
      shutdown <= 1'b1;
    end else begin
      levelCode <= level_reg;
      shutdown <= state_reg == ST_SHUTDOWN;
      if (state_reg == ST_SHUTDOWN || level_reg == 5'h00) begin
        lightMode <= LIGHT_OFF;
        outputOn <= 1'b0;
        currentTenthPct <= 10'h000;
      end else begin
        lightMode <= selSync2_reg ? LIGHT_TORCH : LIGHT_FLASH;
        // Level 16 is the zero-current code
        outputOn <= !(timerArmed && timerExpired_reg) && level_reg != LevelMax;
        currentTenthPct <= (timerArmed && timerExpired_reg) ? 10'h000
          : PctTable[level_reg];
      end
    end
  end

  assign status = '{timerExpired: timerExpired_reg, timerArmed: timerArmed,
    outputOn: outputOn, shutdown: shutdown, lightMode: lightMode,
    pumpMode: pumpMode, levelCode: level_reg};

  // APB slave: one wait-free access, answer prepared during setup
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr == AddrTimerCap) begin
        prdata <= {24'h000000, timerCap_reg};
      end else if (paddr == AddrStatus) begin
        // Status packs 13 bits; the upper read bits stay zero
        prdata <= {19'h00000, status};
      end else if (paddr == AddrPending) begin
        prdata <= {27'h0000000, pending_reg};
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timerCap_reg <= TimerCapReset;
    end else if (apbWrite && paddr == AddrTimerCap) begin
      timerCap_reg <= pwdata[7:0];
    end
  end

endmodule // pfc_flash_ctrl

module pfc_sync2
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic d,
  output logic q
);

  logic stage1_reg;

  // Only the second stage is read outside; the first may be metastable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1_reg <= d;
      q <= stage1_reg;
    end
  end

endmodule // pfc_sync2

// file: verification/pfc_flash_ctrl_asserts.sv
`timescale 1ns/1ps
module pfc_flash_ctrl_checker
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flashTorchSelectInput,
  input wire logic timerCapacitorPinLow,
  input wire logic [4:0] levelCode,
  input wire logic [9:0] currentTenthPct,
  input wire logic outputOn,
  input wire pfc_light_t lightMode,
  input wire pfc_pump_t pumpMode,
  input wire logic pumpReset,
  input wire logic shutdown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("ready too long");
  slverr_with_ready_a: assert property (pslverr |-> pready) else $error("stray slverr");
  level_saturates_a: assert property (levelCode <= LevelMax)
    else $error("level above top");
  pct_table_a: assert property (outputOn |-> currentTenthPct == PctTable[levelCode])
    else $error("current off table");
  top_level_dark_a: assert property (levelCode == LevelMax |-> !outputOn)
    else $error("top level lit");
  shutdown_clears_a: assert property (shutdown && $past(shutdown) |->
    levelCode == 5'h00 && !outputOn) else $error("shutdown not cleared");
  latch_pump_a: assert property ($changed(levelCode) |-> $past(pumpReset))
    else $error("no pump reset on latch");
  pump_restart_a: assert property (pumpReset |-> ##[0:1] pumpMode == PUMP_1X)
    else $error("pump not 1X");
  pump_step_a: assert property ($changed(pumpMode) |-> pumpMode == PUMP_1X ||
    pumpMode == pfc_pump_t'($past(pumpMode) + 2'h1)) else $error("pump skipped");
  // Select reaches lightMode through two sync flops and the output flop
  torch_select_a: assert property (!shutdown && levelCode != 5'h00 |->
    lightMode == ($past(flashTorchSelectInput, 3) ? LIGHT_TORCH : LIGHT_FLASH))
    else $error("bad mode");
  pin_low_on_a: assert property ($past(timerCapacitorPinLow) && !shutdown &&
    levelCode inside {[5'h01:5'h0F]} |-> outputOn) else $error("timer not disabled");
endmodule // pfc_flash_ctrl_checker

bind pfc_flash_ctrl pfc_flash_ctrl_checker chk (.clk, .reset, .psel, .penable, .pready,
  .pslverr, .flashTorchSelectInput, .timerCapacitorPinLow, .levelCode, .currentTenthPct,
  .outputOn, .lightMode, .pumpMode, .pumpReset, .shutdown);

// file: verification/pfc_gpio_host.sv
`timescale 1ns/1ps
module pfc_gpio_host (
  input wire logic clk,
  output logic enSetPin,
  output logic timerCapacitorPinLow
);
  initial enSetPin = 1'b0;
  // Only ground or released, never driven high
  initial timerCapacitorPinLow = 1'b0;
  // Full code every burst, pulses well above filter length
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk) enSetPin <= 1'b0;
      repeat (8) @(posedge clk);
      enSetPin <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic hold(input logic lvl, input int c);
    @(posedge clk) enSetPin <= lvl;
    repeat (c) @(posedge clk);
  endtask
  task automatic pinGround(input logic on);
    @(posedge clk) timerCapacitorPinLow <= on;
  endtask
endmodule // pfc_gpio_host

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pfc_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic flashTorchSelectInput = 0, headroomShort = 0, enSetPin, timerCapacitorPinLow;
  logic pready, pslverr, outputOn, pumpReset, shutdown;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [4:0] levelCode;
  logic [9:0] currentTenthPct;
  pfc_light_t lightMode;
  pfc_pump_t pumpMode;
  logic [15:0] lfsr = 16'h5FB0;
  int n_fail = 0, n_compared = 0, cyc = 0, e;
  int pctTab[17] = '{0, 1000, 891, 794, 708, 631, 562, 501, 447, 398, 355, 316, 282, 251,
    224, 200, 0};
  int codes[8] = '{3, 1, 4, 5, 15, 16, 20, 2};
  pfc_flash_ctrl uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .enSetPin, .flashTorchSelectInput, .timerCapacitorPinLow,
    .headroomShort, .levelCode, .currentTenthPct, .outputOn, .lightMode, .pumpMode,
    .pumpReset, .shutdown);
  pfc_gpio_host host (.clk, .enSetPin, .timerCapacitorPinLow);
  initial forever #50 clk = ~clk;
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Answer taken at the edge that samples pready, released right after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lfsr <= nextRand(lfsr);
    headroomShort <= lfsr[0];
    if (cyc == 70000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    apb(0, AddrTimerCap, 0);
    check(rd, 32'h0000000A);
    apb(1, AddrTimerCap, 32'h00000055);
    apb(0, AddrTimerCap, 0);
    check(rd, 32'h00000055);
    apb(1, AddrStatus, 32'h0000001F);
    apb(0, AddrStatus, 0);
    check(rd[9:0], 10'h220);
    apb(0, 12'h00C, 0);
    check(err, 1'b1);
    check(rd, 0);
    for (int i = 0; i < 8; i++) begin
      flashTorchSelectInput <= lfsr[3]; // Sensed open-drain level only
      host.pinGround(i == 7);
      host.burst(codes[i]);
      host.hold(1'b1, 5300);
      e = codes[i] > 16 ? 16 : codes[i];
      check(levelCode, e);
      check(currentTenthPct, pctTab[e]);
      check(outputOn, e < 16);
      check(lightMode, flashTorchSelectInput ? LIGHT_TORCH : LIGHT_FLASH);
      apb(0, AddrStatus, 0);
      check(rd[11], e <= 4 && i != 7);
      apb(0, AddrPending, 0);
      check(rd[4:0], 0);
    end
    // Shortest timer: cap 0 expires about 1 ms after the pin is released
    apb(1, AddrTimerCap, 32'h00000000);
    host.pinGround(1'b0);
    host.hold(1'b1, 10100);
    check(outputOn, 1'b0);
    check(currentTenthPct, 0);
    check(levelCode, 2);
    apb(0, AddrStatus, 0);
    check(rd[12:11], 2'h3);
    host.pinGround(1'b1);
    host.hold(1'b1, 4);
    check(outputOn, 1'b1);
    check(currentTenthPct, pctTab[2]);
    host.hold(1'b0, 5300);
    check({shutdown, outputOn, levelCode}, 7'h40);
    check(lightMode, LIGHT_OFF);
    check(pumpMode, PUMP_1X);
    conclude;
  end
endmodule // tb_top
